// ---- bus_condition_detect.v ----
`timescale 1ns/10ps

module bus_condition_detect
(
  input wire sys_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg start_seen_q,
  output reg stop_seen_q
);

  // ----------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------
  reg scl_meta_q;
  reg scl_sync_q;
  reg sda_meta_q;
  reg sda_sync_q;
  reg scl_prev_q;
  reg sda_prev_q;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_meta_q <= scl_in;
      scl_sync_q <= scl_meta_q;
      sda_meta_q <= sda_in;
      sda_sync_q <= sda_meta_q;
      scl_prev_q <= scl_sync_q;
      sda_prev_q <= sda_sync_q;
    end
  end

  // ----------------------------------------
  // Start and stop recognition
  // ----------------------------------------
  // Data edge while clock stays high on both samples
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
    end
    else
    begin
      start_seen_q <= scl_prev_q & scl_sync_q & sda_prev_q & ~sda_sync_q;
      stop_seen_q <= scl_prev_q & scl_sync_q & ~sda_prev_q & sda_sync_q;
    end
  end

endmodule // bus_condition_detect

// ---- bus_flag_block.v ----
// Summary of operation
// R1: Reset loads flag register with zero
// R2: Fail and busy flags are read-only
// R3: Mode bits writable only while disabled
// R4: Single bits or whole byte writable
// R5: Failed start without reservation sets fail
// R6: Start request or disable clears fail
// R7: Stop, disable or reset clears busy
// R8: Start, or enabling without initial start, sets busy
// R9: Enable starts busy as inverse of initial
// R10: Start generation waits for free bus
// R11: Start detection or write zero clears initial
// R12: Reservation bit changes only by write/reset
// R13: Software checks bus before first start
// R14: Bits five to two read zero
`timescale 1ns/10ps
`include "bus_flag_regs.vh"

module bus_flag_block
(
  input wire sys_clk,
  input wire rst,
  input wire [`ADDR_W-1:0] addr,
  input wire [7:0] wr_data,
  input wire [7:0] wr_mask,
  input wire wr_strobe,
  input wire rd_strobe,
  output reg [7:0] rd_data_q,
  input wire scl_in,
  input wire sda_in,
  output reg start_go_q,
  output reg operation_enable_q,
  output reg bus_busy_flag_q,
  output reg irq_q
);

  // ----------------------------------------
  // Condition detection on the bus
  // ----------------------------------------
  wire start_seen;
  wire stop_seen;

  bus_condition_detect u_detect
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_seen_q(start_seen),
    .stop_seen_q(stop_seen)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg start_fail_flag_q;
  reg initial_start_enable_q;
  reg reservation_disable_q;
  reg start_request_q;
  reg op_en_prev_q;
  reg [`EVT_W-1:0] evt_status_q;
  reg [`EVT_W-1:0] evt_mask_q;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire sel_flag;
  wire sel_ctl;
  wire sel_stat;
  wire sel_mask;
  wire wr_flag;
  wire wr_ctl;
  wire wr_stat;
  wire wr_mask_reg;

  assign sel_flag = (addr == `OFS_BUS_FLAG_AND_MODE);
  assign sel_ctl = (addr == `OFS_CONTROL_REG_ZERO);
  assign sel_stat = (addr == `OFS_EVENT_STATUS);
  assign sel_mask = (addr == `OFS_EVENT_MASK);
  assign wr_flag = wr_strobe & sel_flag;
  assign wr_ctl = wr_strobe & sel_ctl;
  assign wr_stat = wr_strobe & sel_stat;
  assign wr_mask_reg = wr_strobe & sel_mask;

  // Lane qualifiers; flag bits 7 and 6 get none, see R2
  wire wr_op_en_lane;
  wire wr_req_lane;
  wire wr_ise_lane;
  wire wr_rsv_lane;

  assign wr_op_en_lane = wr_ctl & wr_mask[`BIT_OPERATION_ENABLE]; // see R4
  assign wr_req_lane = wr_ctl & wr_mask[`BIT_START_REQUEST]; // see R4
  // Mode bits locked while the interface runs
  assign wr_ise_lane = wr_flag & wr_mask[`BIT_INITIAL_START_ENABLE]
    & ~operation_enable_q; // see R3
  assign wr_rsv_lane = wr_flag & wr_mask[`BIT_RESERVATION_DISABLE]
    & ~operation_enable_q; // see R3

  // Software asks for a start by writing a one
  wire req_write_one;

  assign req_write_one = wr_req_lane & wr_data[`BIT_START_REQUEST];

  // ----------------------------------------
  // Start arbitration
  // ----------------------------------------
  wire enable_rise;
  wire start_possible;
  wire start_launch;
  wire start_refused;

  assign enable_rise = operation_enable_q & ~op_en_prev_q;
  // Busy flag also covers the initial state chosen at enable
  assign start_possible = ~bus_busy_flag_q & ~start_seen; // see R10
  assign start_launch = operation_enable_q & start_request_q
    & start_possible;
  // With reservation on, a busy bus just keeps the request pending
  assign start_refused = operation_enable_q & start_request_q
    & ~start_possible & reservation_disable_q; // see R5

  // ----------------------------------------
  // Control register zero
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      operation_enable_q <= 1'b0;
      op_en_prev_q <= 1'b0;
    end
    else
    begin
      op_en_prev_q <= operation_enable_q;
      if (wr_op_en_lane)
      begin
        operation_enable_q <= wr_data[`BIT_OPERATION_ENABLE];
      end
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      start_request_q <= 1'b0;
    end
    else if (!operation_enable_q)
    begin
      start_request_q <= 1'b0;
    end
    else if (start_refused || start_launch)
    begin
      start_request_q <= 1'b0; // see R5
    end
    else if (wr_req_lane)
    begin
      start_request_q <= wr_data[`BIT_START_REQUEST];
    end
  end

  // Pulse to the start generator
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      start_go_q <= 1'b0;
    end
    else
    begin
      start_go_q <= start_launch; // see R10
    end
  end

  // ----------------------------------------
  // Bus flag and mode register
  // ----------------------------------------
  // Hardware set wins over the write that clears it
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      start_fail_flag_q <= 1'b0; // see R1
    end
    else if (!operation_enable_q)
    begin
      start_fail_flag_q <= 1'b0; // see R6
    end
    else if (start_refused)
    begin
      start_fail_flag_q <= 1'b1; // see R5
    end
    else if (req_write_one)
    begin
      start_fail_flag_q <= 1'b0; // see R6
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      bus_busy_flag_q <= 1'b0; // see R1 R7
    end
    else if (!operation_enable_q)
    begin
      bus_busy_flag_q <= 1'b0; // see R7
    end
    else if (enable_rise)
    begin
      bus_busy_flag_q <= ~initial_start_enable_q; // see R8 R9
    end
    else if (start_seen)
    begin
      bus_busy_flag_q <= 1'b1; // see R8
    end
    else if (stop_seen)
    begin
      bus_busy_flag_q <= 1'b0; // see R7
    end
  end

  // Detection only counts while the interface runs
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      initial_start_enable_q <= 1'b0; // see R1 R11
    end
    else if (operation_enable_q && start_seen)
    begin
      initial_start_enable_q <= 1'b0; // see R11
    end
    else if (wr_ise_lane)
    begin
      initial_start_enable_q <= wr_data[`BIT_INITIAL_START_ENABLE];
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      reservation_disable_q <= 1'b0; // see R1 R12
    end
    else if (wr_rsv_lane)
    begin
      reservation_disable_q <= wr_data[`BIT_RESERVATION_DISABLE]; // see R12
    end
  end

  // ----------------------------------------
  // Event status and mask
  // ----------------------------------------
  wire [`EVT_W-1:0] evt_raw;

  assign evt_raw[`EVT_START_SEEN] = operation_enable_q & start_seen;
  assign evt_raw[`EVT_STOP_SEEN] = operation_enable_q & stop_seen;
  assign evt_raw[`EVT_START_FAIL] = start_refused;

  genvar gi;
  generate
    for (gi = 0; gi < `EVT_W; gi = gi + 1)
    begin : g_evt
      always @(posedge sys_clk)
      begin
        if (rst)
        begin
          evt_status_q[gi] <= 1'b0;
        end
        else if (evt_raw[gi])
        begin
          evt_status_q[gi] <= 1'b1;
        end
        else if (wr_stat && wr_mask[gi] && wr_data[gi])
        begin
          evt_status_q[gi] <= 1'b0;
        end
      end

      always @(posedge sys_clk)
      begin
        if (rst)
        begin
          evt_mask_q[gi] <= 1'b0;
        end
        else if (wr_mask_reg && wr_mask[gi])
        begin
          evt_mask_q[gi] <= wr_data[gi];
        end
      end
    end
  endgenerate

  // Registered, so it follows status by one cycle
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(evt_status_q & evt_mask_q);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg [7:0] rd_next;

  always @*
  begin
    rd_next = `RD_ZERO; // see R14
    if (sel_flag)
    begin
      rd_next[`BIT_START_FAIL_FLAG] = start_fail_flag_q;
      rd_next[`BIT_BUS_BUSY_FLAG] = bus_busy_flag_q;
      rd_next[`BIT_INITIAL_START_ENABLE] = initial_start_enable_q;
      rd_next[`BIT_RESERVATION_DISABLE] = reservation_disable_q;
    end
    else if (sel_ctl)
    begin
      rd_next[`BIT_OPERATION_ENABLE] = operation_enable_q;
      rd_next[`BIT_START_REQUEST] = start_request_q;
    end
    else if (sel_stat)
    begin
      rd_next[`EVT_W-1:0] = evt_status_q;
    end
    else if (sel_mask)
    begin
      rd_next[`EVT_W-1:0] = evt_mask_q;
    end
  end

  // Unmapped reads return zero; data stands for one cycle only
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      rd_data_q <= `RD_ZERO;
    end
    else if (rd_strobe)
    begin
      rd_data_q <= rd_next;
    end
    else
    begin
      rd_data_q <= `RD_ZERO;
    end
  end

endmodule // bus_flag_block

// ---- bus_flag_block_bench.sv ----
`timescale 1ns/10ps
`include "bus_flag_regs.vh"
module bus_flag_block_bench;
  localparam logic [15:0] flg = `OFS_BUS_FLAG_AND_MODE;
  localparam logic [15:0] ctl = `OFS_CONTROL_REG_ZERO;
  localparam logic [15:0] sts = `OFS_EVENT_STATUS;
  localparam logic [15:0] msk = `OFS_EVENT_MASK;
  logic sys_clk, rst, wr_strobe, rd_strobe;
  logic [15:0] addr;
  logic [7:0] wr_data, wr_mask, rd_data_q;
  wire scl, sda;
  logic start_go_q, operation_enable_q, bus_busy_flag_q, irq_q;
  int n_errors, comparisons, n_go, cycles;
  bus_flag_block u_bus_flag_block (.sys_clk(sys_clk), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_mask(wr_mask),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data_q(rd_data_q),
    .scl_in(scl), .sda_in(sda), .start_go_q(start_go_q),
    .operation_enable_q(operation_enable_q),
    .bus_busy_flag_q(bus_busy_flag_q), .irq_q(irq_q));
  i2c_party party (.sys_clk(sys_clk), .scl(scl), .sda(sda));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ------
  // Access tasks and checking
  // ------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, m);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_mask <= m;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
    #1 chk(rd_data_q, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (start_go_q === 1'b1)
      n_go <= n_go + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      conclude();
    end
  end
  initial
  begin
    {rst, wr_strobe, rd_strobe, addr, wr_data, wr_mask} = 35'h400000000;
    {n_errors, comparisons, n_go, cycles} = '0;
    idle(3);
    rst <= 1'b0;
    rd(flg, 8'h00);
    wr(flg, 8'hff, 8'hff);
    rd(flg, 8'h03);
    wr(flg, 8'h00, 8'h02);
    rd(flg, 8'h01);
    wr(flg, 8'h02, 8'hff);
    rd(flg, 8'h02);
    wr(16'hff00, 8'hff, 8'hff);
    rd(16'hff00, 8'h00);
    wr(ctl, 8'h80, 8'h80);
    rd(ctl, 8'h80);
    wr(flg, 8'h01, 8'hff);
    rd(flg, 8'h02);
    // Bus assumed free here; nobody else is talking
    wr(ctl, 8'h02, 8'h02);
    idle(3);
    chk(n_go[7:0], 8'h01);
    party.frame(1'b1, 1'b0);
    idle(6);
    rd(flg, 8'h40);
    wr(ctl, 8'h02, 8'h02);
    rd(ctl, 8'h82);
    idle(4);
    chk(n_go[7:0], 8'h01);
    party.frame(1'b0, 1'b1);
    idle(6);
    chk(n_go[7:0], 8'h02);
    rd(sts, 8'h03);
    wr(sts, 8'h07, 8'hff);
    rd(sts, 8'h00);
    wr(ctl, 8'h00, 8'h80);
    wr(flg, 8'h01, 8'hff);
    wr(ctl, 8'h80, 8'h80);
    idle(3);
    chk({7'h0, bus_busy_flag_q}, 8'h01);
    chk({7'h0, operation_enable_q}, 8'h01);
    wr(ctl, 8'h02, 8'h02);
    idle(2);
    rd(flg, 8'hc1);
    chk(n_go[7:0], 8'h02);
    rd(sts, 8'h04);
    wr(msk, 8'h04, 8'hff);
    idle(2);
    chk({7'h0, irq_q}, 8'h01);
    wr(msk, 8'h00, 8'hff);
    idle(2);
    chk({7'h0, irq_q}, 8'h00);
    wr(msk, 8'h04, 8'hff);
    wr(sts, 8'h04, 8'hff);
    idle(2);
    chk({7'h0, irq_q}, 8'h00);
    wr(ctl, 8'h00, 8'h80);
    idle(1);
    rd(flg, 8'h01);
    // Conditions while disabled must leave everything alone
    party.frame(1'b1, 1'b1);
    idle(6);
    rd(flg, 8'h01);
    rd(sts, 8'h00);
    // Mid-run reset must drop the mode bits set above
    idle(1);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rd(flg, 8'h00);
    conclude();
  end
endmodule // bus_flag_block_bench

// ---- bus_flag_block_sva.sv ----
`timescale 1ns/10ps
`include "bus_flag_regs.vh"
module bus_flag_block_sva
(
  input wire sys_clk,
  input wire rst,
  input wire [15:0] addr,
  input wire [7:0] wr_data,
  input wire [7:0] wr_mask,
  input wire wr_strobe,
  input wire rd_strobe,
  input wire [7:0] rd_data_q,
  input wire scl_in,
  input wire sda_in,
  input wire start_go_q,
  input wire operation_enable_q,
  input wire bus_busy_flag_q,
  input wire irq_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire rd_flag = rd_strobe && addr == `OFS_BUS_FLAG_AND_MODE;
  // ------
  // Bus conditions, raw pins; allow for the synchroniser
  // ------
  sequence start_cond;
    operation_enable_q && scl_in && $fell(sda_in);
  endsequence
  sequence stop_cond;
    operation_enable_q && scl_in && $rose(sda_in);
  endsequence
  sequence off_twice;
    !operation_enable_q ##1 !operation_enable_q;
  endsequence
  a_rst_zero: assert property ($fell(rst) |-> rd_data_q == 8'h00 &&
    !start_go_q && !irq_q && !operation_enable_q && !bus_busy_flag_q)
    else $error("outputs not zero after reset");
  a_zero_bits: assert property (rd_flag |=> rd_data_q[5:2] == 4'h0)
    else $error("reserved flag bits not zero");
  a_busy_read: assert property (
    rd_flag |=> rd_data_q[6] == $past(bus_busy_flag_q))
    else $error("busy bit read differs from busy output");
  a_fail_off: assert property ((off_twice ##0 rd_flag) |=> !rd_data_q[7])
    else $error("fail flag set while disabled");
  a_busy_off: assert property (off_twice |-> !bus_busy_flag_q)
    else $error("busy while disabled");
  a_busy_start: assert property (start_cond |-> ##[1:6] bus_busy_flag_q)
    else $error("start did not set busy");
  a_busy_stop: assert property (stop_cond |-> ##[1:6] !bus_busy_flag_q)
    else $error("stop did not clear busy");
  a_go_free: assert property (start_go_q |->
    !$past(bus_busy_flag_q) && $past(operation_enable_q))
    else $error("start launched on busy bus");
  a_rd_idle: assert property (!rd_strobe |=> rd_data_q == 8'h00)
    else $error("read data outside read cycle");
endmodule // bus_flag_block_sva
bind bus_flag_block bus_flag_block_sva u_sva (.sys_clk(sys_clk), .rst(rst),
  .addr(addr), .wr_data(wr_data), .wr_mask(wr_mask),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data_q(rd_data_q),
  .scl_in(scl_in), .sda_in(sda_in), .start_go_q(start_go_q),
  .operation_enable_q(operation_enable_q),
  .bus_busy_flag_q(bus_busy_flag_q), .irq_q(irq_q));

// ---- bus_flag_regs.vh ----
`ifndef BUS_FLAG_REGS_VH
`define BUS_FLAG_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_W 16
`define OFS_BUS_FLAG_AND_MODE 16'hffaa
`define OFS_CONTROL_REG_ZERO 16'hffa6
`define OFS_EVENT_STATUS 16'hffac
`define OFS_EVENT_MASK 16'hffad

// ----------------------------------------
// Field positions, bus flag and mode
// ----------------------------------------
`define BIT_START_FAIL_FLAG 7
`define BIT_BUS_BUSY_FLAG 6
`define BIT_INITIAL_START_ENABLE 1
`define BIT_RESERVATION_DISABLE 0

// ----------------------------------------
// Field positions, control register zero
// ----------------------------------------
`define BIT_OPERATION_ENABLE 7
`define BIT_START_REQUEST 1

// ----------------------------------------
// Field positions, event status and mask
// ----------------------------------------
`define EVT_W 3
`define EVT_START_SEEN 0
`define EVT_STOP_SEEN 1
`define EVT_START_FAIL 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BUS_FLAG_AND_MODE 8'h00
`define RST_CONTROL_REG_ZERO 8'h00
`define RST_EVENT 3'h0
`define RD_ZERO 8'h00

`endif

// ---- i2c_party.sv ----
`timescale 1ns/10ps
module i2c_party
(
  input wire sys_clk,
  output logic scl,
  output logic sda
);
  // ------
  // Other master; lines pulled high, clock still between frames
  // ------
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hold;
    repeat (4) @(posedge sys_clk);
  endtask
  // Half of a 160 ns link period is four cycles
  task automatic frame(input bit start, input bit stop);
    @(posedge sys_clk);
    if (start)
      sda <= 1'b0;
    hold();
    repeat (3)
    begin
      scl <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
    end
    if (stop)
    begin
      scl <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      sda <= 1'b1;
      hold();
    end
  endtask
endmodule // i2c_party
